// ===== core/dsac_core.sv
/*
  DMA channel support: checksum sniffer, abort with drain, request credits,
  debug views, two interrupt lines and channel chaining.
  Assumes the transfer engine returns one done pulse per issued transfer
  and that FIFO traffic is presented one word per cycle with its channel.
*/
// The placing of the registers and the plain strobed port were chosen for this implementation.
// Function
// - Sniffer watches only channels with watch enable.
// - Sniffer folds one full word every cycle.
// - CRC-32, CRC-16 both orders, sum, parity.
// - Result register readable and writable for seeding.
// - Result manipulations change only the read view.
// - Sniffer only observes; FIFO data untouched.
// - Clearing enable pauses, keeps count and state.
// - Abort register: one bit per channel, 1 aborts.
// - Abort clears remaining count, leaves channel inactive.
// - In-flight transfers at abort still complete.
// - Busy stays set until in-flight transfers drain.
// - Debug views show credits and count, can reset.
// - Enabled completion raises its interrupt line.
// - Completion starts the chained channel at once.
// - Chained completion interrupts in same event.
// - Register aliases reorder words, last is trigger.
// - Request pulses add saturating credit, issue subtracts.
// - Writing masked status clears those interrupts.
// - All-zero trigger write does not start channel.
`timescale 1ns/10ps
module dsac_core
  import dsac_pkg::*;
#(
  parameter int NUM_CH = CH_N,
  parameter int REQ_LINES = REQ_N
)
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic [REQ_LINES-1:0] dreq_in,
  input wire logic [NUM_CH-1:0] done_in,
  input wire logic fifo_valid_in,
  input wire logic [CH_W-1:0] fifo_chan_in,
  input wire logic [31:0] fifo_data_in,
  output logic [NUM_CH-1:0] issue_out,
  output logic irq0_out,
  output logic irq1_out
);
  generate
    if (NUM_CH != CH_N || REQ_LINES > 63 || REQ_LINES < 1)
    begin : g_bad_param
      $error("dsac_core channel or request line count unsupported.");
    end
  endgenerate

  dsac_state_t s_reg;
  dsac_state_t s_next;
  logic in_ch;
  logic in_dbg;
  logic [CH_W-1:0] a_ch;
  logic [1:0] a_wd;
  logic [1:0] fsel;
  logic [CH_N-1:0] abort_w;
  logic [63:0] dreq_pad;
  logic [CH_W-1:0] sn_sel;
  logic watch;
  logic [31:0] step_w;
  logic [31:0] sn_view;
  logic [CH_N-1:0] comp;
  logic [CH_N-1:0] start;
  logic [CH_N-1:0] nulltrig;
  logic [CH_N-1:0] pulse;
  logic [CH_N-1:0] busy;

  // Address decode; channel rows repeat per alias with a different word order.
  assign in_ch = (addr_in < CH_TOP);
  assign in_dbg = (addr_in >= DBG_BASE) && (addr_in < DBG_TOP);
  assign a_ch = addr_in[6 +: CH_W];
  assign a_wd = addr_in[3:2];
  assign fsel = ALIAS_MAP[addr_in[5:4]][a_wd];
  assign abort_w = (wr_in && addr_in == OFS_ABORT) ? wdata_in[CH_N-1:0] : '0;
  assign dreq_pad = 64'(dreq_in);

  // The sniffer taps the FIFO word without driving anything back into it.
  assign sn_sel = s_reg.sctl[SN_CH +: CH_W];
  assign watch = s_reg.sctl[SN_EN] && fifo_valid_in && (fifo_chan_in == sn_sel)
    && s_reg.ch[sn_sel].ctrl[CTL_SNIFF];

  dsac_sniff_step #(
    .DATA_W(32)
  ) u_step (
    .mode_in(dsac_mode_t'(s_reg.sctl[SN_MODE +: 3])),
    .acc_in(s_reg.acc),
    .data_in(fifo_data_in),
    .acc_out(step_w)
  );

  // Read view of the result; the accumulator itself is never altered here.
  always_comb
  begin
    logic [31:0] v;
    v = s_reg.acc;
    if (s_reg.sctl[SN_REV])
    begin
      v = {<<{v}};
    end
    if (s_reg.sctl[SN_INV])
    begin
      v = ~v;
    end
    if (s_reg.sctl[SN_SWAP])
    begin
      v = {v[7:0], v[15:8], v[23:16], v[31:24]};
    end
    sn_view = v;
  end

  // All channel, interrupt and sniffer state advances here.
  always_comb
  begin
    logic granted;
    logic paced;
    logic take;
    logic [5:0] req_sel;
    logic [3:0] tgt;
    logic [CH_N-1:0] clr;
    granted = 1'b0;
    paced = 1'b0;
    take = 1'b0;
    req_sel = 6'h00;
    tgt = 4'h0;
    clr = '0;
    s_next = s_reg;
    s_next.issue = '0;
    s_next.rdata = 32'h00000000;
    comp = '0;
    start = '0;
    nulltrig = '0;
    pulse = '0;
    busy = '0;
    for (int i = 0; i < CH_N; i++)
    begin
      busy[i] = (s_reg.ch[i].state != ST_IDLE);
      req_sel = s_reg.ch[i].ctrl[CTL_REQ +: 6];
      paced = (req_sel != REQ_NONE);
      pulse[i] = paced && (int'(req_sel) < REQ_LINES) && dreq_pad[req_sel];
      // Enable low only withholds issue; count and state stay put.
      take = (s_reg.ch[i].state == ST_RUN) && s_reg.ch[i].ctrl[CTL_EN]
        && (s_reg.ch[i].remain != 32'h00000000) && !abort_w[i]
        && (!paced || s_reg.ch[i].credit != '0) && (s_reg.ch[i].inflight != '1)
        && !granted;
      granted = granted | take;
      s_next.issue[i] = take;
      // Saturating credit, one per request pulse, one back per paced issue.
      if (pulse[i] && !(take && paced) && s_reg.ch[i].credit != '1)
      begin
        s_next.ch[i].credit = s_reg.ch[i].credit + 1'b1;
      end
      else if (take && paced && !pulse[i])
      begin
        s_next.ch[i].credit = s_reg.ch[i].credit - 1'b1;
      end
      if (take)
      begin
        s_next.ch[i].remain = s_reg.ch[i].remain - 32'h00000001;
      end
      // Issued transfers cannot be revoked, so their done pulses are always counted.
      if (take && !(done_in[i] && s_reg.ch[i].inflight != '0))
      begin
        s_next.ch[i].inflight = s_reg.ch[i].inflight + 1'b1;
      end
      else if (!take && done_in[i] && s_reg.ch[i].inflight != '0)
      begin
        s_next.ch[i].inflight = s_reg.ch[i].inflight - 1'b1;
      end
      case (s_reg.ch[i].state)
        ST_IDLE: s_next.ch[i].state = ST_IDLE;
        ST_RUN:
          if (s_reg.ch[i].remain == 32'h00000000 && s_reg.ch[i].inflight == '0)
          begin
            s_next.ch[i].state = ST_IDLE;
            comp[i] = 1'b1;
          end
        ST_DRAIN:
          if (s_reg.ch[i].inflight == '0)
          begin
            s_next.ch[i].state = ST_IDLE;
          end
        default: s_next.ch[i].state = ST_IDLE;
      endcase
      // Abort drops the count, skips completion and waits out in-flight work.
      if (abort_w[i])
      begin
        s_next.ch[i].remain = 32'h00000000;
        s_next.ch[i].state = (s_next.ch[i].inflight != '0) ? ST_DRAIN : ST_IDLE;
        comp[i] = 1'b0;
      end
    end

    // Register writes; a trigger slot starts the channel only on a nonzero word.
    if (wr_in && in_ch)
    begin
      case (fsel)
        F_RD: s_next.ch[a_ch].rd_addr = wdata_in;
        F_WR: s_next.ch[a_ch].wr_addr = wdata_in;
        F_CNT: s_next.ch[a_ch].count = wdata_in;
        default: s_next.ch[a_ch].ctrl = wdata_in & CTL_WMASK;
      endcase
      if (a_wd == TRIG_WORD)
      begin
        start[a_ch] = (wdata_in != 32'h00000000) && !abort_w[a_ch];
        nulltrig[a_ch] = (wdata_in == 32'h00000000);
      end
    end
    else if (wr_in && in_dbg)
    begin
      // Debug views double as a way to reset a stuck channel.
      if (a_wd == DBG_CREDIT)
      begin
        s_next.ch[a_ch].credit = '0;
      end
      else if (a_wd == DBG_COUNT)
      begin
        s_next.ch[a_ch].remain = wdata_in;
      end
    end
    else if (wr_in)
    begin
      case (addr_in)
        OFS_IRQ_LINE0_MASK: s_next.irq_line0_mask = wdata_in[CH_N-1:0];
        OFS_IRQ_LINE1_MASK: s_next.irq_line1_mask = wdata_in[CH_N-1:0];
        OFS_INTS0: clr = wdata_in[CH_N-1:0];
        OFS_INTS1: clr = wdata_in[CH_N-1:0];
        OFS_SNCTL: s_next.sctl = wdata_in[8:0];
        default: clr = '0;
      endcase
    end

    // A completing channel restarts its chain target in the same cycle.
    for (int i = 0; i < CH_N; i++)
    begin
      tgt = s_reg.ch[i].ctrl[CTL_CHAIN +: 4];
      if (comp[i] && int'(tgt) < CH_N && int'(tgt) != i && !abort_w[tgt[CH_W-1:0]])
      begin
        start[tgt[CH_W-1:0]] = 1'b1;
      end
    end
    for (int i = 0; i < CH_N; i++)
    begin
      if (start[i])
      begin
        s_next.ch[i].state = ST_RUN;
        s_next.ch[i].remain = s_next.ch[i].count;
      end
    end

    // Non-quiet completions and quiet null triggers set flags; a set beats a clear.
    for (int i = 0; i < CH_N; i++)
    begin
      s_next.raw[i] = (s_reg.raw[i] && !clr[i])
        || (comp[i] && !s_reg.ch[i].ctrl[CTL_QUIET])
        || (nulltrig[i] && s_next.ch[i].ctrl[CTL_QUIET]);
    end
    s_next.irq0 = |(s_reg.raw & s_reg.irq_line0_mask);
    s_next.irq1 = |(s_reg.raw & s_reg.irq_line1_mask);

    // A seed write wins over a word folded in the same cycle.
    if (wr_in && addr_in == OFS_SNRES)
    begin
      s_next.acc = wdata_in;
    end
    else if (watch)
    begin
      s_next.acc = step_w;
    end

    // Read data stand in the cycle after the strobe; unmapped reads give zero.
    if (rd_in && in_ch)
    begin
      case (fsel)
        F_RD: s_next.rdata = s_reg.ch[a_ch].rd_addr;
        F_WR: s_next.rdata = s_reg.ch[a_ch].wr_addr;
        F_CNT: s_next.rdata = s_reg.ch[a_ch].count;
        default: s_next.rdata = s_reg.ch[a_ch].ctrl | (32'(busy[a_ch]) << CTL_BUSY);
      endcase
    end
    else if (rd_in && in_dbg)
    begin
      if (a_wd == DBG_CREDIT)
      begin
        s_next.rdata = 32'(s_reg.ch[a_ch].credit);
      end
      else if (a_wd == DBG_COUNT)
      begin
        s_next.rdata = s_reg.ch[a_ch].remain;
      end
    end
    else if (rd_in)
    begin
      case (addr_in)
        OFS_INTR: s_next.rdata = 32'(s_reg.raw);
        OFS_IRQ_LINE0_MASK: s_next.rdata = 32'(s_reg.irq_line0_mask);
        OFS_IRQ_LINE1_MASK: s_next.rdata = 32'(s_reg.irq_line1_mask);
        OFS_INTS0: s_next.rdata = 32'(s_reg.raw & s_reg.irq_line0_mask);
        OFS_INTS1: s_next.rdata = 32'(s_reg.raw & s_reg.irq_line1_mask);
        OFS_SNCTL: s_next.rdata = 32'(s_reg.sctl);
        OFS_SNRES: s_next.rdata = sn_view;
        OFS_ABORT: s_next.rdata = 32'(busy);
        default: s_next.rdata = 32'h00000000;
      endcase
    end
  end

  // Single state register for the whole block.
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_reg <= STATE_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign rdata_out = s_reg.rdata;
  assign issue_out = s_reg.issue;
  assign irq0_out = s_reg.irq0;
  assign irq1_out = s_reg.irq1;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  sniff_off_a: assert property (!watch && !(wr_in && addr_in == OFS_SNRES)
    |=> $stable(s_reg.acc)) else $error("Checksum moved without a watched word.");
  sniff_step_a: assert property (watch && !wr_in |=> s_reg.acc == $past(step_w))
    else $error("Watched word was not folded in.");
  one_issue_a: assert property ($onehot0(issue_out))
    else $error("More than one transfer issued in a cycle.");
  irq_line_a: assert property (|(s_reg.raw & s_reg.irq_line0_mask) |=> irq0_out)
    else $error("Enabled channel flag did not raise line 0.");

  generate
    for (genvar i = 0; i < CH_N; i++)
    begin : g_chk
      // One-hot copy of this channel's chain target, kept only for the chain check.
      logic [CH_N-1:0] chain_hot;
      assign chain_hot = {{(CH_N - 1){1'b0}}, 1'b1} << s_reg.ch[i].ctrl[CTL_CHAIN +: CH_W];
      sequence abort_busy_s;
        abort_w[i] && s_reg.ch[i].inflight != '0 && !done_in[i];
      endsequence
      abort_clear_a: assert property (abort_w[i]
        |=> s_reg.ch[i].state != ST_RUN && s_reg.ch[i].remain == 32'h00000000)
        else $error("Abort left the channel running.");
      abort_drain_a: assert property (abort_busy_s |=> busy[i] ##0
        s_reg.ch[i].state == ST_DRAIN) else $error("Busy dropped with work in flight.");
      abort_zero_a: assert property (wr_in && addr_in == OFS_ABORT && !wdata_in[i]
        && s_reg.ch[i].state == ST_RUN && s_reg.ch[i].remain > 32'h00000001
        |=> s_reg.ch[i].state == ST_RUN) else $error("Zero abort bit stopped channel.");
      null_trig_a: assert property (nulltrig[i] && !start[i] && s_reg.ch[i].state == ST_IDLE
        |=> s_reg.ch[i].state == ST_IDLE) else $error("Null trigger started channel.");
      credit_up_a: assert property (pulse[i] && !s_next.issue[i] && s_reg.ch[i].credit != '1
        && !(wr_in && in_dbg && a_wd == DBG_CREDIT && int'(a_ch) == i)
        |=> s_reg.ch[i].credit == $past(s_reg.ch[i].credit) + 1'b1)
        else $error("Request pulse did not add credit.");
      chain_go_a: assert property (comp[i] && !s_reg.ch[i].ctrl[CTL_QUIET]
        && int'(s_reg.ch[i].ctrl[CTL_CHAIN +: 4]) < CH_N
        && int'(s_reg.ch[i].ctrl[CTL_CHAIN +: 4]) != i && (abort_w & chain_hot) == '0
        |=> s_reg.raw[i] && (busy & $past(chain_hot)) != '0)
        else $error("Chained completion lost its flag or its start.");
    end
  endgenerate
endmodule : dsac_core

// ===== core/dsac_sniff_step.sv
/*
  One checksum step over a full data word, purely combinational.
  Assumes the caller registers the result and feeds it back as the accumulator.
*/
`timescale 1ns/10ps
module dsac_sniff_step
  import dsac_pkg::*;
#(
  parameter int DATA_W = 32
)
(
  input wire dsac_mode_t mode_in,
  input wire logic [31:0] acc_in,
  input wire logic [DATA_W-1:0] data_in,
  output logic [31:0] acc_out
);
  generate
    if (DATA_W != 32)
    begin : g_bad_width
      $error("dsac_sniff_step serves 32-bit words only.");
    end
  endgenerate

  // The whole word is folded in one cycle, so the sniffer never lags the FIFO.
  always_comb
  begin
    logic [31:0] c;
    logic fb;
    c = acc_in;
    fb = 1'b0;
    case (mode_in)
      MODE_CRC32_MSB:
        for (int i = DATA_W - 1; i >= 0; i--)
        begin
          fb = c[31] ^ data_in[i];
          c = {c[30:0], 1'b0} ^ (fb ? POLY32 : 32'h00000000);
        end
      MODE_CRC32_LSB:
        for (int i = 0; i < DATA_W; i++)
        begin
          fb = c[0] ^ data_in[i];
          c = {1'b0, c[31:1]} ^ (fb ? POLY32_REV : 32'h00000000);
        end
      MODE_CRC16_MSB:
        for (int i = DATA_W - 1; i >= 0; i--)
        begin
          fb = c[15] ^ data_in[i];
          c = {16'h0000, c[14:0], 1'b0} ^ {16'h0000, (fb ? POLY16 : 16'h0000)};
        end
      MODE_CRC16_LSB:
        for (int i = 0; i < DATA_W; i++)
        begin
          fb = c[0] ^ data_in[i];
          c = {17'h00000, c[15:1]} ^ {16'h0000, (fb ? POLY16_REV : 16'h0000)};
        end
      MODE_SUM: c = acc_in + data_in;
      MODE_PARITY: c = {31'h00000000, acc_in[0] ^ (^data_in)};
      default: c = acc_in;
    endcase
    acc_out = c;
  end
endmodule : dsac_sniff_step

// ===== inc/dsac_pkg.sv
/*
  Shared constants and types for the DMA checksum sniffer, abort and chain block.
  Assumes a 12-bit byte address on the register port and a 32-bit data word.
*/
package dsac_pkg;
  localparam int CH_N = 4;
  localparam int CH_W = 2;
  localparam int CREDIT_W = 6;
  localparam int INFL_W = 4;
  localparam int REQ_N = 40;
  localparam int AW = 12;

  // Register slots of one alias row; the row order differs per alias, word 3 triggers.
  localparam logic [1:0] F_RD = 2'h0;
  localparam logic [1:0] F_WR = 2'h1;
  localparam logic [1:0] F_CNT = 2'h2;
  localparam logic [1:0] F_CTL = 2'h3;
  localparam logic [1:0] TRIG_WORD = 2'h3;
  localparam logic [3:0][3:0][1:0] ALIAS_MAP = {
    {F_RD, F_CNT, F_WR, F_CTL}, {F_WR, F_RD, F_CNT, F_CTL},
    {F_CNT, F_WR, F_RD, F_CTL}, {F_CTL, F_CNT, F_WR, F_RD}};

  // Address map.
  localparam logic [AW-1:0] CH_TOP = 12'h100;
  localparam logic [AW-1:0] OFS_INTR = 12'h400;
  localparam logic [AW-1:0] OFS_IRQ_LINE0_MASK = 12'h404;
  localparam logic [AW-1:0] OFS_INTS0 = 12'h40C;
  localparam logic [AW-1:0] OFS_IRQ_LINE1_MASK = 12'h414;
  localparam logic [AW-1:0] OFS_INTS1 = 12'h41C;
  localparam logic [AW-1:0] OFS_SNCTL = 12'h434;
  localparam logic [AW-1:0] OFS_SNRES = 12'h438;
  localparam logic [AW-1:0] OFS_ABORT = 12'h444;
  localparam logic [AW-1:0] DBG_BASE = 12'h800;
  localparam logic [AW-1:0] DBG_TOP = 12'h900;
  localparam logic [1:0] DBG_CREDIT = 2'h0;
  localparam logic [1:0] DBG_COUNT = 2'h1;

  // Channel control word fields.
  localparam int CTL_EN = 0;
  localparam int CTL_CHAIN = 1;
  localparam int CTL_QUIET = 5;
  localparam int CTL_SNIFF = 6;
  localparam int CTL_REQ = 7;
  localparam int CTL_BUSY = 24;
  localparam logic [31:0] CTL_WMASK = 32'h00001FFF;
  localparam logic [31:0] CTL_RST = 32'h00001F9E;
  localparam logic [5:0] REQ_NONE = 6'h3F;

  // Checksum control fields.
  localparam int SN_EN = 0;
  localparam int SN_CH = 1;
  localparam int SN_MODE = 3;
  localparam int SN_REV = 6;
  localparam int SN_INV = 7;
  localparam int SN_SWAP = 8;

  localparam logic [31:0] POLY32 = 32'h04C11DB7;
  localparam logic [31:0] POLY32_REV = 32'hEDB88320;
  localparam logic [15:0] POLY16 = 16'h1021;
  localparam logic [15:0] POLY16_REV = 16'h8408;

  typedef enum logic [2:0] {
    MODE_CRC32_MSB = 3'h0,
    MODE_CRC32_LSB = 3'h1,
    MODE_CRC16_MSB = 3'h2,
    MODE_CRC16_LSB = 3'h3,
    MODE_SUM = 3'h4,
    MODE_PARITY = 3'h5
  } dsac_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1,
    ST_DRAIN = 2'h3
  } dsac_chst_t;

  typedef struct packed {
    dsac_chst_t state;
    logic [31:0] rd_addr;
    logic [31:0] wr_addr;
    logic [31:0] count;
    logic [31:0] ctrl;
    logic [31:0] remain;
    logic [CREDIT_W-1:0] credit;
    logic [INFL_W-1:0] inflight;
  } dsac_chan_t;

  typedef struct packed {
    dsac_chan_t [CH_N-1:0] ch;
    logic [CH_N-1:0] raw;
    logic [CH_N-1:0] irq_line0_mask;
    logic [CH_N-1:0] irq_line1_mask;
    logic [CH_N-1:0] issue;
    logic [8:0] sctl;
    logic [31:0] acc;
    logic [31:0] rdata;
    logic irq0;
    logic irq1;
  } dsac_state_t;

  localparam dsac_chan_t CHAN_RST = '{state: ST_IDLE, ctrl: CTL_RST, default: '0};
  localparam dsac_state_t STATE_RST = '{ch: {CH_N{CHAN_RST}}, default: '0};
endpackage : dsac_pkg

// ===== sim/dsac_far_model.sv
/*
  Far-side model: bus fabric that retires every issued transfer after a delay.
  Assumes issue pulses last one cycle; slow mode keeps transfers in flight.
*/
`timescale 1ns/10ps
module dsac_far_model
  import dsac_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic slow_in,
  input wire logic [CH_N-1:0] issue_in,
  output logic [CH_N-1:0] done_out
);
  int pend[CH_N];
  int age[CH_N];

  // Transfers once issued are never revoked, so each one always retires.
  always @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      done_out <= '0;
      for (int i = 0; i < CH_N; i++)
      begin
        pend[i] = 0;
        age[i] = 0;
      end
    end
    else
    begin
      for (int i = 0; i < CH_N; i++)
      begin
        done_out[i] <= 1'b0;
        if (issue_in[i])
          pend[i]++;
        if (pend[i] > 0 && age[i] >= (slow_in ? 12 : 1))
        begin
          done_out[i] <= 1'b1;
          pend[i]--;
          age[i] = 0;
        end
        else if (pend[i] > 0)
          age[i]++;
      end
    end
  end
endmodule : dsac_far_model

// ===== sim/tb.sv
/*
  Self-checking bench for the channel support block: register bus master,
  request pulses, FIFO word stream and the far-side model.
  Assumes the address map and control word layout of the shared package.
*/
`timescale 1ns/10ps
module tb
  import dsac_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [AW-1:0] addr_in = '0;
  logic [31:0] wdata_in = '0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic [REQ_N-1:0] dreq_in = '0;
  logic [CH_N-1:0] done_in;
  logic fifo_valid_in = 1'b0;
  logic [CH_W-1:0] fifo_chan_in = '0;
  logic [31:0] fifo_data_in = '0;
  logic [CH_N-1:0] issue_out;
  logic irq0_out;
  logic irq1_out;
  logic slow = 1'b0;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int icnt[CH_N] = '{default: 0};
  int seed = 32'h13c4;

  dsac_core uut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .dreq_in(dreq_in), .done_in(done_in), .fifo_valid_in(fifo_valid_in),
    .fifo_chan_in(fifo_chan_in), .fifo_data_in(fifo_data_in), .issue_out(issue_out),
    .irq0_out(irq0_out), .irq1_out(irq1_out));
  dsac_far_model far (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .slow_in(slow),
    .issue_in(issue_out), .done_out(done_in));

  // Clock and hang guard; issues are counted on the falling edge, clear of updates.
  always #20 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  always @(negedge clk_sys_in)
    for (int i = 0; i < CH_N; i++)
      if (issue_out[i] === 1'b1)
        icnt[i]++;

  task automatic end_of_test();
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic bw(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask : bw

  // Read data stand only in the cycle after the strobe, so sample just then.
  task automatic rchk(input logic [AW-1:0] a, input logic [31:0] exp, input string m);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, exp, m);
  endtask : rchk

  task automatic pulse(input int k);
    @(posedge clk_sys_in);
    dreq_in <= 40'h1 << k;
    @(posedge clk_sys_in);
    dreq_in <= '0;
  endtask : pulse

  task automatic wirq(input bit l);
    int k;
    k = 0;
    while (((l ? irq1_out : irq0_out) !== 1'b1) && k < 400)
    begin
      @(negedge clk_sys_in);
      k++;
    end
    chk({31'h0, l ? irq1_out : irq0_out}, 32'h1, "irq line missing");
  endtask : wirq

  function automatic logic [31:0] fold(input logic [2:0] m, input logic [31:0] a,
    input logic [31:0] d);
    logic [31:0] r;
    r = a;
    if (m == 3'h4)
      return a + d;
    if (m == 3'h5)
      return {31'h0, a[0] ^ (^d)};
    for (int i = 0; i < 32; i++)
      case (m)
        3'h0: r = {r[30:0], 1'b0} ^ ({32{r[31] ^ d[31-i]}} & POLY32);
        3'h1: r = (r >> 1) ^ ({32{r[0] ^ d[i]}} & POLY32_REV);
        3'h2: r = {16'h0, r[14:0], 1'b0} ^ {16'h0, {16{r[15] ^ d[31-i]}} & POLY16};
        default: r = {17'h0, r[15:1]} ^ {16'h0, {16{r[0] ^ d[i]}} & POLY16_REV};
      endcase
    return r;
  endfunction : fold

  // Reverse, then invert, then byte swap, as the read view applies them.
  function automatic logic [31:0] view(input logic [31:0] a, input logic [2:0] b);
    logic [31:0] r;
    r = a;
    if (b[0])
      r = {<<{r}};
    if (b[1])
      r = ~r;
    if (b[2])
      r = {<<8{r}};
    return r;
  endfunction : view

  // Main sequence.
  initial
  begin
    logic [31:0] n, m, acc, d, ctl;
    logic [2:0] b;
    logic [CH_W-1:0] c;
    int k;
    repeat (20) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    rchk(12'h00C, CTL_RST, "control reset value");
    rchk(12'h200, 32'h0, "unmapped read");
    bw(12'h200, $random(seed));
    n = ({$random(seed)} % 6) + 1;
    bw(OFS_IRQ_LINE0_MASK, 32'h1);
    bw(12'h008, n);
    bw(12'h00C, 32'h1F9F);
    wirq(1'b0);
    chk(icnt[0], n, "issue count");
    rchk(OFS_INTS0, 32'h1, "masked status");
    bw(OFS_INTS0, 32'h1);
    repeat (3) @(posedge clk_sys_in);
    chk({31'h0, irq0_out}, 32'h0, "irq not cleared");
    rchk(OFS_INTR, 32'h0, "raw not cleared");
    icnt = '{default: 0};
    m = ({$random(seed)} % 5) + 1;
    bw(12'h050, 32'h1F9F);
    bw(12'h048, m);
    bw(OFS_IRQ_LINE1_MASK, 32'h2);
    bw(12'h010, 32'h1F83);
    bw(12'h01C, n);
    wirq(1'b1);
    chk(icnt[0], n, "chain source count");
    chk(icnt[1], m, "chain target count");
    rchk(OFS_INTR, 32'h3, "both flags raised");
    bw(OFS_INTS0, 32'h1);
    bw(OFS_INTS1, 32'h2);
    bw(12'h090, 32'h1FBF);
    bw(12'h09C, 32'h0);
    repeat (4) @(posedge clk_sys_in);
    chk(icnt[2], 32'h0, "null trigger started");
    rchk(OFS_INTR, 32'h4, "quiet null flag");
    bw(OFS_INTS0, 32'h4);
    // The other two alias rows reach the same words in their own order.
    rchk(12'h0A0, 32'h1FBF, "alias 2 control view");
    d = $random(seed);
    bw(12'h0B4, d);
    rchk(12'h084, d, "alias 3 write pointer");
    d = $random(seed);
    bw(12'h0A8, d);
    rchk(12'h0BC, d, "alias 2 read pointer");
    bw(12'h010, 32'h1FDE);
    for (int md = 0; md < 6; md++)
    begin
      ctl = {23'h0, 3'h0, md[2:0], 2'h0, 1'b1};
      acc = (md == 2 || md == 3) ? {16'h0, 16'($random(seed))} : $random(seed);
      bw(OFS_SNCTL, ctl);
      bw(OFS_SNRES, acc);
      for (int w = 0; w < 8; w++)
      begin
        c = w[0] ? CH_W'(1 + {$random(seed)} % 3) : '0;
        d = $random(seed);
        if (c == 0)
          acc = fold(md[2:0], acc, d);
        @(posedge clk_sys_in);
        fifo_valid_in <= 1'b1;
        fifo_chan_in <= c;
        fifo_data_in <= d;
      end
      @(posedge clk_sys_in);
      fifo_valid_in <= 1'b0;
      rchk(OFS_SNRES, acc, "checksum result");
      b = 3'($random(seed));
      bw(OFS_SNCTL, ctl | {23'h0, b, 6'h0});
      rchk(OFS_SNRES, view(acc, b), "result view");
      bw(OFS_SNCTL, ctl);
      rchk(OFS_SNRES, acc, "view left sum alone");
    end
    bw(12'h010, 32'h1F9E);
    bw(OFS_SNCTL, 32'h21);
    bw(OFS_SNRES, acc);
    @(posedge clk_sys_in);
    fifo_valid_in <= 1'b1;
    fifo_chan_in <= '0;
    fifo_data_in <= 32'h5A5A5A5A;
    @(posedge clk_sys_in);
    fifo_valid_in <= 1'b0;
    rchk(OFS_SNRES, acc, "unwatched word folded");
    k = {$random(seed)} % REQ_N;
    ctl = 32'h1F | (k << 7);
    slow <= 1'b1;
    bw(12'h0D0, ctl);
    repeat (3) pulse(k);
    rchk(12'h8C0, 32'h3, "credit count");
    bw(12'h0DC, 32'h5);
    repeat (6) @(posedge clk_sys_in);
    chk(icnt[3], 32'h3, "paced issue count");
    bw(12'h0D0, ctl & ~32'h1);
    rchk(12'h8C4, 32'h2, "paused count kept");
    bw(OFS_ABORT, 32'h0);
    rchk(12'h8C4, 32'h2, "zero abort kept count");
    bw(OFS_IRQ_LINE0_MASK, 32'h0);
    bw(OFS_ABORT, 32'h8);
    rchk(12'h8C4, 32'h0, "abort left count");
    rchk(OFS_ABORT, 32'h8, "busy during drain");
    rchk(OFS_ABORT, 32'h8, "busy during drain");
    repeat (60) @(posedge clk_sys_in);
    rchk(OFS_ABORT, 32'h0, "busy after drain");
    chk(icnt[3], 32'h3, "issue after abort");
    rchk(OFS_INTR, 32'h0, "flag after abort");
    pulse(k);
    rchk(12'h8C0, 32'h1, "credit after pulse");
    bw(12'h8C0, 32'h0);
    rchk(12'h8C0, 32'h0, "credit clear");
    slow <= 1'b0;
    end_of_test();
  end
endmodule : tb
